// File: gcu_pkg.sv
package gcu_pkg;

    // ------------------------------------------------------------------
    // register map (index times four gives the byte address)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 9;
    localparam logic [5:0] REG_FMT_IDX = 6'h04;
    localparam logic [5:0] REG_CTRL_IDX = 6'h05;
    localparam logic [5:0] REG_STAT_IDX = 6'h06;
    localparam logic [REG_W-1:0] FMT_RESET = 9'h000;
    localparam logic [REG_W-1:0] CTRL_RESET = 9'h000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TX_LAW = 1;
    localparam int CTRL_TX_EN = 2;
    localparam int CTRL_RX_LAW = 3;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_EIGHT = 5;
    localparam int FMT_WL_LSB = 5;
    localparam int STAT_TXV = 4;

    // ------------------------------------------------------------------
    // serial word lengths in bits
    // ------------------------------------------------------------------
    localparam logic [5:0] WL_BITS_8 = 6'h08;
    localparam logic [5:0] WL_BITS_16 = 6'h10;
    localparam logic [5:0] WL_BITS_20 = 6'h14;
    localparam logic [5:0] WL_BITS_24 = 6'h18;
    localparam logic [5:0] WL_BITS_32 = 6'h20;

    // ------------------------------------------------------------------
    // law constants and the bus wait count
    // ------------------------------------------------------------------
    localparam logic [13:0] MU_CLIP = 14'h1FDE;
    localparam logic [13:0] MU_BIAS = 14'h0021;
    localparam logic [15:0] MU_DEC_BIAS = 16'h0084;
    localparam logic [7:0] A_XOR = 8'h55;
    localparam int BUS_WAIT_CYC = 1;

    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } gcu_bus_state_t;

endpackage

// File: gcu_stream_if.sv
`timescale 1ns/100ps
// valid/ready word stream between the block's own modules
interface gcu_stream_if #(
    parameter int W = 16
);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface

// File: gcu_fifo.sv
`timescale 1ns/100ps
// small flop fifo; DEPTH must be a power of two so pointers wrap naturally
module gcu_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
)(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // streams
    gcu_stream_if.snk wr,
    gcu_stream_if.src rd,
    // fill state
    output logic room2_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [LW-1:0] count;
    logic [LW-1:0] next_count;
    logic push;
    logic pop;

    // -------------------------------------------------------------------
    // handshakes
    // -------------------------------------------------------------------
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;
    assign wr.ready = (count != LW'(DEPTH));
    assign rd.valid = (count != '0);
    assign rd.data = mem[rd_ptr];
    assign level_o = count;

    // occupancy
    always_comb begin
        next_count = count + LW'(push) - LW'(pop);
    end

    // count and the two-slot room flag; room2 lets a one-deep stage upstream never be refused
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count <= '0;
            room2_o <= 1'b1;
        end else begin
            count <= next_count;
            room2_o <= (next_count <= LW'(DEPTH - 2));
        end
    end

    // pointers
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
        end
    end

    // storage needs no reset: nothing reads an entry before it is written
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= wr.data;
        end
    end
endmodule

// File: gcu_top.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Functional notes
// R01: compressor maps 13-bit linear (mu-law) or 12-bit (A-law) to 8 bits.
// R02: each code is sign, 3-bit exponent, 4-bit mantissa.
// R03: mu-law follows the G.711 logarithmic curve, mu equal to 255.
// R04: A-law follows the G.711 piecewise curve, A equal to 87.6.
// R05: control bit 2 enables transmit companding; bit 1 picks A-law.
// R06: control bit 4 enables receive companding; bit 3 picks A-law; default off.
// R07: software sets an 8-bit serial word length whenever companding is on.
// R08: control bit 5 forces 8-bit words, ignoring the format word length field.
// R09: receive expander turns each 8-bit code back into linear with the same law.
module gcu_top #(
    parameter int SAMPLE_W = 16,
    parameter int FIFO_DEPTH = 8
)(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // register bus
    input wire logic [gcu_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [gcu_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [gcu_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // adc sample stream in
    input wire logic [SAMPLE_W-1:0] adc_sample_i,
    input wire logic adc_valid_i,
    output logic adc_ready_o,
    // transmit words to the serial interface
    output logic [SAMPLE_W-1:0] tx_word_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // receive words from the serial interface
    input wire logic [SAMPLE_W-1:0] rx_word_i,
    input wire logic rx_valid_i,
    // dac sample stream out
    output logic [SAMPLE_W-1:0] dac_sample_o,
    output logic dac_valid_o,
    // serial word length in force
    output logic [5:0] serial_word_bits_o
);
    import gcu_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH+1);

    // -------------------------------------------------------------------
    // law functions
    // -------------------------------------------------------------------

    // mu-law compress of a 14-bit two's complement sample (13-bit magnitude)
    function automatic logic [7:0] mu_enc(input logic [13:0] s);
        logic [13:0] mag;
        logic [2:0] seg;
        logic [3:0] mant;
        mag = s[13] ? 14'(-s) : s;
        if (mag > MU_CLIP) begin
            mag = MU_CLIP;
        end
        mag = mag + MU_BIAS;
        seg = 3'h0;
        for (int i = 6; i <= 12; i++) begin
            if (mag[i]) begin
                seg = 3'(i - 5);
            end
        end
        mant = 4'(mag >> (4'(seg) + 4'h1));
        return ~{s[13], seg, mant};
    endfunction

    // A-law compress of a 13-bit two's complement sample (12-bit magnitude)
    function automatic logic [7:0] a_enc(input logic [12:0] s);
        logic [11:0] mag;
        logic [2:0] seg;
        logic [2:0] sh;
        logic [3:0] mant;
        mag = s[12] ? ~s[11:0] : s[11:0];
        seg = 3'h0;
        for (int i = 5; i <= 11; i++) begin
            if (mag[i]) begin
                seg = 3'(i - 4);
            end
        end
        sh = (seg == 3'h0) ? 3'h1 : seg;
        mant = 4'(mag >> sh);
        return {~s[12], seg, mant} ^ A_XOR;
    endfunction

    // mu-law expand to a 16-bit linear sample
    function automatic logic [15:0] mu_dec(input logic [7:0] c);
        logic [7:0] u;
        logic [15:0] t;
        u = ~c;
        t = (16'({u[3:0], 3'h0}) + MU_DEC_BIAS) << u[6:4];
        return u[7] ? 16'(MU_DEC_BIAS - t) : 16'(t - MU_DEC_BIAS);
    endfunction

    // A-law expand to a 16-bit linear sample
    function automatic logic [15:0] a_dec(input logic [7:0] c);
        logic [7:0] u;
        logic [15:0] t;
        u = c ^ A_XOR;
        t = 16'({u[3:0], 4'h8});
        if (u[6:4] != 3'h0) begin
            t = (t + 16'h0100) << 3'(u[6:4] - 3'h1);
        end
        return u[7] ? t : 16'(-t);
    endfunction

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    gcu_bus_state_t bus_state;
    logic [REG_W-1:0] fmt_reg;
    logic [REG_W-1:0] ctrl_reg;
    logic [5:0] reg_idx;
    logic bus_req;
    logic bus_wr;
    logic [DATA_W-1:0] next_rdata;
    logic [LW-1:0] fifo_level;
    logic fifo_room2;
    logic adc_take;
    logic stg_valid;
    logic [SAMPLE_W-1:0] stg_word;
    logic [SAMPLE_W-1:0] next_stg_word;
    logic pop_take;
    logic tx_en;
    logic tx_alaw;
    logic rx_en;
    logic rx_alaw;
    logic eight_bit_word_select;
    logic [1:0] word_length_field;

    gcu_stream_if #(.W(SAMPLE_W)) push_if();
    gcu_stream_if #(.W(SAMPLE_W)) pop_if();

    assign tx_en = ctrl_reg[CTRL_TX_EN];
    assign tx_alaw = ctrl_reg[CTRL_TX_LAW];
    assign rx_en = ctrl_reg[CTRL_RX_EN];
    assign rx_alaw = ctrl_reg[CTRL_RX_LAW];
    assign eight_bit_word_select = ctrl_reg[CTRL_EIGHT];
    assign word_length_field = fmt_reg[FMT_WL_LSB +: 2];

    // -------------------------------------------------------------------
    // register bus slave
    // -------------------------------------------------------------------
    assign reg_idx = avs_address_i[ADDR_W-1:2];
    assign bus_req = avs_read_i || avs_write_i;
    assign bus_wr = avs_write_i && !avs_waitrequest_o;

    // one wait cycle per access gives read data a full cycle to settle
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bus_state <= BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state <= BUS_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_state <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        next_rdata = '0;
        case (reg_idx)
            REG_FMT_IDX: begin
                next_rdata[REG_W-1:0] = fmt_reg;
            end
            REG_CTRL_IDX: begin
                next_rdata[REG_W-1:0] = ctrl_reg;
            end
            REG_STAT_IDX: begin
                next_rdata[LW-1:0] = fifo_level;
                next_rdata[STAT_TXV] = tx_valid_o;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // read data latched as the wait is lifted
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_readdata_o <= '0;
        end else if (bus_state == BUS_IDLE && avs_read_i) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // writes land at the edge where waitrequest is seen low, per byte lane
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fmt_reg <= FMT_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (bus_wr) begin
            if (reg_idx == REG_FMT_IDX) begin
                if (avs_byteenable_i[0]) begin
                    fmt_reg[7:0] <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    fmt_reg[8] <= avs_writedata_i[8];
                end
            end
            if (reg_idx == REG_CTRL_IDX) begin
                if (avs_byteenable_i[0]) begin
                    ctrl_reg[7:0] <= avs_writedata_i[7:0];
                end
                if (avs_byteenable_i[1]) begin
                    ctrl_reg[8] <= avs_writedata_i[8];
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // serial word length
    // -------------------------------------------------------------------

    // eight-bit select overrides the format field entirely
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            serial_word_bits_o <= WL_BITS_16;
        end else if (eight_bit_word_select) begin
            serial_word_bits_o <= WL_BITS_8; // R08
        end else begin
            case (word_length_field)
                2'h0: serial_word_bits_o <= WL_BITS_16;
                2'h1: serial_word_bits_o <= WL_BITS_20;
                2'h2: serial_word_bits_o <= WL_BITS_24;
                default: serial_word_bits_o <= WL_BITS_32;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // transmit path: compress, stage, fifo
    // -------------------------------------------------------------------
    assign adc_ready_o = fifo_room2;
    assign adc_take = adc_valid_i && adc_ready_o;

    // law choice; mu-law uses the top 14 bits, A-law the top 13
    always_comb begin
        next_stg_word = adc_sample_i;
        if (tx_en) begin // R05
            if (tx_alaw) begin
                next_stg_word = {{(SAMPLE_W-8){1'b0}}, a_enc(adc_sample_i[SAMPLE_W-1 -: 13])}; // R04 R01
            end else begin
                next_stg_word = {{(SAMPLE_W-8){1'b0}}, mu_enc(adc_sample_i[SAMPLE_W-1 -: 14])}; // R03 R01
            end
        end
    end

    // one-deep stage; room2 guarantees the fifo never refuses it
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stg_valid <= 1'b0;
            stg_word <= '0;
        end else begin
            stg_valid <= adc_take;
            if (adc_take) begin
                stg_word <= next_stg_word; // R02
            end
        end
    end

    assign push_if.valid = stg_valid;
    assign push_if.data = stg_word;

    gcu_fifo #(
        .W(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wr(push_if.snk),
        .rd(pop_if.src),
        .room2_o(fifo_room2),
        .level_o(fifo_level)
    );

    // output register refills as soon as the serial side takes a word
    assign pop_take = !tx_valid_o || tx_ready_i;
    assign pop_if.ready = pop_take;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_valid_o <= 1'b0;
            tx_word_o <= '0;
        end else if (pop_take) begin
            tx_valid_o <= pop_if.valid;
            if (pop_if.valid) begin
                tx_word_o <= pop_if.data;
            end
        end
    end

    // -------------------------------------------------------------------
    // receive path: expand to the dac
    // -------------------------------------------------------------------

    // no back-pressure here: the dac side takes one sample per frame
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_valid_o <= 1'b0;
            dac_sample_o <= '0;
        end else begin
            dac_valid_o <= rx_valid_i;
            if (rx_valid_i) begin
                if (!rx_en) begin // R06
                    dac_sample_o <= rx_word_i;
                end else if (rx_alaw) begin
                    dac_sample_o <= SAMPLE_W'(a_dec(rx_word_i[7:0])) << (SAMPLE_W - 16); // R09
                end else begin
                    dac_sample_o <= SAMPLE_W'(mu_dec(rx_word_i[7:0])) << (SAMPLE_W - 16); // R09
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_ctrl_write;
        avs_write_i && !avs_waitrequest_o && reg_idx == REG_CTRL_IDX && avs_byteenable_i[0];
    endsequence

    sequence s_adc_in(logic en, logic law);
        adc_take && tx_en == en && tx_alaw == law;
    endsequence

    property p_bus_answer;
        bus_req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait cycle"); // R05

    property p_ctrl_write;
        s_ctrl_write |=> tx_en == $past(avs_writedata_i[CTRL_TX_EN]) && rx_en == $past(avs_writedata_i[CTRL_RX_EN]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write not applied"); // R06

    property p_word8;
        s_ctrl_write ##0 avs_writedata_i[CTRL_EIGHT] |=> ##1 serial_word_bits_o == WL_BITS_8;
    endproperty
    a_word8: assert property (p_word8) else $error("eight-bit select did not force 8-bit words"); // R08

    property p_word_field;
        !eight_bit_word_select && word_length_field == 2'h0 |=> serial_word_bits_o == WL_BITS_16;
    endproperty
    a_word_field: assert property (p_word_field) else $error("word length field not followed"); // R08

    property p_tx_mu;
        s_adc_in(1'b1, 1'b0) |=> stg_valid && stg_word[7:0] == mu_enc($past(adc_sample_i[SAMPLE_W-1 -: 14]));
    endproperty
    a_tx_mu: assert property (p_tx_mu) else $error("mu-law code wrong"); // R03

    property p_tx_a;
        s_adc_in(1'b1, 1'b1) |=> stg_valid && stg_word[7:0] == a_enc($past(adc_sample_i[SAMPLE_W-1 -: 13]));
    endproperty
    a_tx_a: assert property (p_tx_a) else $error("A-law code wrong"); // R04

    property p_code_width;
        s_adc_in(1'b1, tx_alaw) |=> stg_word[SAMPLE_W-1:8] == '0;
    endproperty
    a_code_width: assert property (p_code_width) else $error("companded word wider than 8 bits"); // R01

    property p_tx_bypass;
        adc_take && !tx_en |=> stg_word == $past(adc_sample_i);
    endproperty
    a_tx_bypass: assert property (p_tx_bypass) else $error("bypass altered sample"); // R05

    property p_rx_expand;
        rx_valid_i && rx_en |=> dac_valid_o && dac_sample_o[SAMPLE_W-1 -: 16] ==
            ($past(rx_alaw) ? a_dec($past(rx_word_i[7:0])) : mu_dec($past(rx_word_i[7:0])));
    endproperty
    a_rx_expand: assert property (p_rx_expand) else $error("receive expansion wrong"); // R09

    property p_push_room;
        stg_valid |-> push_if.ready;
    endproperty
    a_push_room: assert property (p_push_room) else $error("fifo refused staged word"); // R02
endmodule

// File: gcu_serial_model.sv
`timescale 1ns/100ps
// -----------------------------------------------------------
// stand-in for the serial audio side of the block
// -----------------------------------------------------------
module gcu_serial_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // pacing chosen by the bench
    input wire logic stall_i,
    input wire logic slow_i,
    // transmit words from the block
    input wire logic [15:0] tx_word_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    // receive words to the block
    output logic [15:0] rx_word_o,
    output logic rx_valid_o
);
    logic [15:0] got_q[$];

    // accept pacing; slow mode takes a word every other cycle so the hold gets tested
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= !stall_i && (!slow_i || !tx_ready_o);
        end
    end

    // capture every word taken at an edge; the bench pops the queue, so this is a plain process
    always @(posedge sys_clk_i) begin
        if (!reset_i && tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_word_i);
        end
    end

    // one received word per call; the line carries junk once released
    task automatic send_code(input logic [15:0] w);
        @(posedge sys_clk_i);
        rx_word_o <= w;
        rx_valid_o <= 1'b1;
        @(posedge sys_clk_i);
        rx_word_o <= ~w;
        rx_valid_o <= 1'b0;
    endtask

    // idle receive line at time zero
    initial begin
        rx_word_o = 16'h5A5A;
        rx_valid_o = 1'b0;
    end
endmodule

// File: g711_companding_unit_tb_top.sv
`timescale 1ns/100ps
module g711_companding_unit_tb_top;
    import gcu_pkg::*;
    // -----------------------------------------------------------
    // signals
    // -----------------------------------------------------------
    logic sys_clk, reset, avs_read, avs_write, adc_valid, tx_ready, rx_valid, stall, slow;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic avs_waitrequest, adc_ready, tx_valid, dac_valid;
    logic [15:0] adc_sample, tx_word, rx_word, dac_sample;
    logic [5:0] word_bits;
    int err_total = 0;
    int check_count = 0;

    gcu_top i_dut (.sys_clk_i(sys_clk), .reset_i(reset), .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .adc_sample_i(adc_sample),
        .adc_valid_i(adc_valid), .adc_ready_o(adc_ready), .tx_word_o(tx_word), .tx_valid_o(tx_valid),
        .tx_ready_i(tx_ready), .rx_word_i(rx_word), .rx_valid_i(rx_valid), .dac_sample_o(dac_sample),
        .dac_valid_o(dac_valid), .serial_word_bits_o(word_bits));
    gcu_serial_model i_far (.sys_clk_i(sys_clk), .reset_i(reset), .stall_i(stall), .slow_i(slow),
        .tx_word_i(tx_word), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid));

    // -----------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------
    task automatic stop_test;
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            err_total++;
            stop_test();
        end
    endtask
    // push one sample and wait for its word at the far side
    task automatic tx_one(input logic [15:0] s, input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge sys_clk);
        adc_sample <= s;
        adc_valid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (adc_ready !== 1'b1 && n < 50);
        adc_valid <= 1'b0;
        while (i_far.got_q.size() == 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (i_far.got_q.size() == 0) begin
            err_total++;
            stop_test();
        end
        chk(i_far.got_q.pop_front(), exp);
    endtask

    // -----------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------
    task automatic t_reset_regs;
        chk(word_bits, 6'h10);
        bus(0, 8'h10, 0, rd);
        chk(rd, 32'h0);
        bus(0, 8'h14, 0, rd);
        chk(rd, 32'h0);
        bus(1, 8'h3C, 32'h1FF, rd);
        bus(0, 8'h3C, 0, rd);
        chk(rd, 32'h0);
        bus(1, 8'h14, 32'hFFFF_FFFF, rd);
        bus(0, 8'h14, 0, rd);
        chk(rd, 32'h1FF);
    endtask
    task automatic t_word_len;
        logic [5:0] bits[4] = '{6'h10, 6'h14, 6'h18, 6'h20};
        bus(1, 8'h14, 0, rd);
        for (int i = 0; i < 4; i++) begin
            bus(1, 8'h10, 32'(i) << 5, rd);
            repeat (2) @(posedge sys_clk);
            chk(word_bits, bits[i]);
        end
        bus(1, 8'h14, 32'h20, rd);
        repeat (2) @(posedge sys_clk);
        chk(word_bits, 6'h08);
    endtask
    // 8-bit mode is set alongside every law the bench enables
    task automatic t_compress;
        logic [8:0] c[8] = '{9'h24, 9'h24, 9'h24, 9'h24, 9'h26, 9'h26, 9'h3E, 9'h38};
        logic [15:0] s[8] = '{16'h0000, 16'h7FFC, 16'h8000, 16'h0190, 16'h0000, 16'h7FF8, 16'h8000, 16'h1234};
        logic [15:0] e[8] = '{16'h00FF, 16'h0080, 16'h0000, 16'h00DF, 16'h00D5, 16'h00AA, 16'h002A, 16'h1234};
        slow <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(1, 8'h14, {23'h0, c[i]}, rd);
            tx_one(s[i], e[i]);
        end
        slow <= 1'b0;
    endtask
    task automatic t_expand;
        logic [8:0] c[7] = '{9'h30, 9'h30, 9'h30, 9'h3E, 9'h38, 9'h38, 9'h26};
        logic [15:0] w[7] = '{16'h00FF, 16'h0080, 16'h0000, 16'h00D5, 16'h00AA, 16'h002A, 16'hBEEF};
        logic [15:0] e[7] = '{16'h0000, 16'h7D7C, 16'h8284, 16'h0008, 16'h7E00, 16'h8200, 16'hBEEF};
        for (int i = 0; i < 7; i++) begin
            bus(1, 8'h14, {23'h0, c[i]}, rd);
            i_far.send_code(w[i]);
            @(posedge sys_clk);
            chk(dac_valid, 1'b1);
            chk(dac_sample, e[i]);
        end
    endtask
    // far side stalls until the buffer refuses, then drains in order
    task automatic t_fifo;
        int k;
        k = 0;
        bus(1, 8'h14, 0, rd);
        stall <= 1'b1;
        @(posedge sys_clk);
        adc_valid <= 1'b1;
        adc_sample <= 16'h0;
        repeat (16) begin
            @(posedge sys_clk);
            if (adc_ready === 1'b1) begin
                k++;
                adc_sample <= 16'(k);
            end
        end
        adc_valid <= 1'b0;
        chk(k >= 7 && k <= 10, 1'b1);
        bus(0, 8'h18, 0, rd);
        chk(rd[4], 1'b1);
        chk(rd[3:0], 32'(k - 1));
        stall <= 1'b0;
        repeat (30) @(posedge sys_clk);
        chk(i_far.got_q.size(), k);
        for (int i = 0; i < k; i++) chk(i_far.got_q.pop_front(), i);
    endtask

    // -----------------------------------------------------------
    // clock, watchdog and main sequence
    // -----------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        stop_test();
    end
    initial begin
        reset = 1'b1;
        {avs_read, avs_write, adc_valid, stall, slow} = '0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        adc_sample = 16'h0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset_regs();
        t_word_len();
        t_compress();
        t_expand();
        t_fifo();
        stop_test();
    end
endmodule
